// ### common/rid_pkg.sv
//Function
//- A status flag sets on its event whatever its enable bit holds.
//- Writing one to a status bit clears it; writing zero leaves it alone.
//- Events are captured in standby; the interrupt shows once active mode returns.
//- Power-on reset brings the tamper status flag up set.
//- Software reset clears all status flags except tamper.
//- Bits 15 to 8 set at 512 down to 4 Hz; bit 7 at 2 Hz.
//- Bits 6 to 3 set on second, minute, hour and day ticks.
//- Bit 2 sets when the alarm value matches the selected counters.
//- Bit 1 sets on countdown expiry; bit 0 on tamper.
//- Enable bit sits beside its flag; clearing it leaves the flag alone.
//- Tamper enable sets on power-on and survives software reset; others default.
//- Alarm select: 00 daily, 01 monthly, 10 yearly, 11 one-time.
//- One interrupt output ORs all enabled sources; software reads status to find it.
//- Countdown decrements by one on each minute tick.
//- Writing zero to the countdown does nothing; zero count means disabled.
//- Countdown flags expiry at zero, reads live, software reset restores default.
//- Countdown value in bits 7:0; bits 15:8 read as zero.
//- Daylight hour and month registers take writes only while daylight enable clear.
//- Begin hour 12:8, finish hour 4:0; shift applied when minute reaches 59.
//- Begin month 11:8, finish month 3:0; other bits read zero.
//- Software reset leaves daylight hour and month registers unchanged.
//- Control bit 6 enables automatic daylight adjustment.
package rid_pkg;
    // ====================================================
    // Register map
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_STATUS = 4'h1;
    localparam logic [3:0] OFF_ENABLE = 4'h2;
    localparam logic [3:0] OFF_COUNT = 4'h3;
    localparam logic [3:0] OFF_HOUR = 4'h4;
    localparam logic [3:0] OFF_MONTH = 4'h5;
    // ====================================================
    // Fields
    localparam int CTRL_SWR_BIT = 8;
    localparam int CTRL_DST_BIT = 6;
    localparam int CTRL_ALM_LSB = 2;
    localparam logic [15:0] CTRL_MASK = 16'h004c;
    localparam logic [15:0] HOUR_MASK = 16'h1f1f;
    localparam logic [15:0] MONTH_MASK = 16'h0f0f;
    localparam logic [15:0] TAMPER_MASK = 16'h0001;
    localparam int BIT_HALF = 7;
    localparam int BIT_SEC = 6;
    localparam int BIT_MIN = 5;
    localparam int BIT_HOUR = 4;
    localparam int BIT_DAY = 3;
    localparam int BIT_ALARM = 2;
    localparam int BIT_COUNT = 1;
    localparam int BIT_TAMPER = 0;
    // ====================================================
    // Reset values
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] STATUS_RST = 16'h0001;
    localparam logic [15:0] ENABLE_RST = 16'h0001;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [15:0] DST_RST = 16'h0000;
    // ====================================================
    // Timing
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned BASE_HZ = 1024;
    localparam int unsigned BASE_DIV = CLK_HZ / BASE_HZ;
    // ====================================================
    // Alarm match select
    typedef enum logic [1:0] {
        ALM_DAILY = 2'h0,
        ALM_MONTHLY = 2'h1,
        ALM_YEARLY = 2'h2,
        ALM_ONCE = 2'h3
    } rid_alarm_type;
endpackage

// ### hw/rid_irq_countdown_dst.sv
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/1ns
module rid_irq_countdown_dst #(
    parameter int unsigned BASE_DIV = rid_pkg::BASE_DIV
) (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wr_data_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    output logic [15:0] rd_data_o,
    input wire logic second_tick_i,
    input wire logic minute_tick_i,
    input wire logic hour_tick_i,
    input wire logic day_tick_i,
    input wire logic tamper_event_i,
    input wire logic alarm_hms_eq_i,
    input wire logic alarm_day_eq_i,
    input wire logic alarm_month_eq_i,
    input wire logic alarm_year_eq_i,
    input wire logic standby_i,
    input wire logic [4:0] cur_hour_i,
    input wire logic [3:0] cur_month_i,
    input wire logic minute_59_i,
    output logic irq_o,
    output logic daylight_adjust_enable_o,
    output logic shift_forward_o,
    output logic shift_back_o
);

    // ====================================================
    // Declarations
    logic [14:0] div_reg;
    logic base_tick;
    logic [8:0] phase_reg;
    logic [15:0] evt;
    logic [15:0] ctrl_reg;
    logic swr_reg;
    logic [15:0] status_reg;
    logic [15:0] status_next;
    logic [15:0] enable_reg;
    logic [7:0] count_reg;
    logic count_load;
    logic count_evt;
    logic [15:0] hour_reg;
    logic [15:0] month_reg;
    logic alarm_match;
    logic alarm_prev_reg;
    logic alarm_evt;
    logic irq_reg;
    logic fwd_reg;
    logic back_reg;
    logic [15:0] rd_data_reg;
    logic wr_ctrl;
    logic wr_status;
    logic wr_enable;
    logic wr_count;
    logic wr_hour;
    logic wr_month;
    logic daylight_adjust_enable;
    rid_pkg::rid_alarm_type alarm_sel;

    // ====================================================
    // Write decode
    assign wr_ctrl = wr_en_i && (addr_i == rid_pkg::OFF_CTRL);
    assign wr_status = wr_en_i && (addr_i == rid_pkg::OFF_STATUS);
    assign wr_enable = wr_en_i && (addr_i == rid_pkg::OFF_ENABLE);
    assign wr_count = wr_en_i && (addr_i == rid_pkg::OFF_COUNT);
    assign wr_hour = wr_en_i && (addr_i == rid_pkg::OFF_HOUR);
    assign wr_month = wr_en_i && (addr_i == rid_pkg::OFF_MONTH);

    // ====================================================
    // Sampling time base
    assign base_tick = (div_reg == 15'(BASE_DIV - 1));

    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i)
        begin
            div_reg <= 15'h0000;
        end
        else if (base_tick)
        begin
            div_reg <= 15'h0000;
        end
        else
        begin
            div_reg <= div_reg + 15'h0001;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i)
        begin
            phase_reg <= 9'h000;
        end
        else if (base_tick)
        begin
            phase_reg <= phase_reg + 9'h001;
        end
    end

    // Rate j fires every 2^(j+1) base ticks
    for (genvar j = 0; j < 9; j++)
    begin : g_rate
        assign evt[15 - j] = base_tick && (&phase_reg[j:0]);
    end

    // ====================================================
    // Event sources
    assign evt[rid_pkg::BIT_SEC] = second_tick_i;
    assign evt[rid_pkg::BIT_MIN] = minute_tick_i;
    assign evt[rid_pkg::BIT_HOUR] = hour_tick_i;
    assign evt[rid_pkg::BIT_DAY] = day_tick_i;
    assign evt[rid_pkg::BIT_ALARM] = alarm_evt;
    assign evt[rid_pkg::BIT_COUNT] = count_evt;
    assign evt[rid_pkg::BIT_TAMPER] = tamper_event_i;

    // ====================================================
    // Control register
    assign daylight_adjust_enable = ctrl_reg[rid_pkg::CTRL_DST_BIT];
    assign alarm_sel = rid_pkg::rid_alarm_type'(ctrl_reg[rid_pkg::CTRL_ALM_LSB +: 2]);
    assign daylight_adjust_enable_o = daylight_adjust_enable;

    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i)
        begin
            ctrl_reg <= rid_pkg::CTRL_RST;
        end
        else if (wr_ctrl)
        begin
            ctrl_reg <= wr_data_i & rid_pkg::CTRL_MASK;
        end
    end

    // Self-clearing software reset pulse
    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i)
        begin
            swr_reg <= 1'b0;
        end
        else
        begin
            swr_reg <= wr_ctrl && wr_data_i[rid_pkg::CTRL_SWR_BIT];
        end
    end

    // ====================================================
    // Status flags
    always_comb
    begin
        status_next = status_reg;
        if (wr_status)
        begin
            status_next = status_next & ~wr_data_i;
        end
        if (swr_reg)
        begin
            status_next = status_next & rid_pkg::TAMPER_MASK;
        end
        status_next = status_next | evt;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i)
        begin
            status_reg <= rid_pkg::STATUS_RST;
        end
        else
        begin
            status_reg <= status_next;
        end
    end

    // ====================================================
    // Enable mask
    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i)
        begin
            enable_reg <= rid_pkg::ENABLE_RST;
        end
        else if (wr_enable)
        begin
            enable_reg <= wr_data_i;
        end
        else if (swr_reg)
        begin
            enable_reg <= (enable_reg & rid_pkg::TAMPER_MASK)
                | (rid_pkg::ENABLE_RST & ~rid_pkg::TAMPER_MASK);
        end
    end

    // ====================================================
    // Interrupt output
    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i)
        begin
            irq_reg <= 1'b0;
        end
        else
        begin
            irq_reg <= (|(status_reg & enable_reg)) && !standby_i;
        end
    end
    assign irq_o = irq_reg;

    // ====================================================
    // Minute countdown
    assign count_load = wr_count && (wr_data_i[7:0] != 8'h00);
    assign count_evt = minute_tick_i && (count_reg == 8'h01) && !count_load;

    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i)
        begin
            count_reg <= rid_pkg::COUNT_RST;
        end
        else if (count_load)
        begin
            count_reg <= wr_data_i[7:0];
        end
        else if (swr_reg)
        begin
            count_reg <= rid_pkg::COUNT_RST;
        end
        else if (minute_tick_i && (count_reg != 8'h00))
        begin
            count_reg <= count_reg - 8'h01;
        end
    end

    // ====================================================
    // Alarm match
    assign alarm_match = alarm_hms_eq_i
        && (alarm_sel == rid_pkg::ALM_DAILY || alarm_day_eq_i)
        && (alarm_sel inside {rid_pkg::ALM_DAILY, rid_pkg::ALM_MONTHLY} || alarm_month_eq_i)
        && (alarm_sel != rid_pkg::ALM_ONCE || alarm_year_eq_i);

    assign alarm_evt = alarm_match && !alarm_prev_reg;

    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i)
        begin
            alarm_prev_reg <= 1'b0;
        end
        else
        begin
            alarm_prev_reg <= alarm_match;
        end
    end

    // ====================================================
    // Daylight hour and month bounds
    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i)
        begin
            hour_reg <= rid_pkg::DST_RST;
        end
        else if (wr_hour && !daylight_adjust_enable)
        begin
            hour_reg <= wr_data_i & rid_pkg::HOUR_MASK;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i)
        begin
            month_reg <= rid_pkg::DST_RST;
        end
        else if (wr_month && !daylight_adjust_enable)
        begin
            month_reg <= wr_data_i & rid_pkg::MONTH_MASK;
        end
    end

    // Shift pulses at minute 59 of the programmed hour
    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i)
        begin
            fwd_reg <= 1'b0;
            back_reg <= 1'b0;
        end
        else
        begin
            fwd_reg <= daylight_adjust_enable && minute_59_i && (cur_hour_i == hour_reg[12:8])
                && (cur_month_i == month_reg[11:8]);
            back_reg <= daylight_adjust_enable && minute_59_i && (cur_hour_i == hour_reg[4:0])
                && (cur_month_i == month_reg[3:0]);
        end
    end
    assign shift_forward_o = fwd_reg;
    assign shift_back_o = back_reg;

    // ====================================================
    // Read port
    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i)
        begin
            rd_data_reg <= 16'h0000;
        end
        else if (rd_en_i)
        begin
            case (addr_i)
                rid_pkg::OFF_CTRL:
                begin
                    rd_data_reg <= ctrl_reg;
                end
                rid_pkg::OFF_STATUS:
                begin
                    rd_data_reg <= status_reg;
                end
                rid_pkg::OFF_ENABLE:
                begin
                    rd_data_reg <= enable_reg;
                end
                rid_pkg::OFF_COUNT:
                begin
                    rd_data_reg <= {8'h00, count_reg};
                end
                rid_pkg::OFF_HOUR:
                begin
                    rd_data_reg <= hour_reg;
                end
                rid_pkg::OFF_MONTH:
                begin
                    rd_data_reg <= month_reg;
                end
                default:
                begin
                    rd_data_reg <= 16'h0000;
                end
            endcase
        end
        else
        begin
            rd_data_reg <= 16'h0000;
        end
    end
    assign rd_data_o = rd_data_reg;

    // ====================================================
    // Checks
    default clocking chk_cb @(posedge core_clk_i);
    endclocking
    default disable iff (!resetn_i);
    flag_set_a: assert property (
        second_tick_i |=> status_reg[rid_pkg::BIT_SEC])
        else $error("second flag not set");
    w1c_clear_a: assert property (
        wr_status && wr_data_i[rid_pkg::BIT_MIN] && !minute_tick_i
        |=> !status_reg[rid_pkg::BIT_MIN])
        else $error("minute flag not cleared");
    swr_status_a: assert property (
        swr_reg && !wr_status
        |=> status_reg[15:1] == $past(evt[15:1])
        && status_reg[0] == ($past(status_reg[0]) || $past(evt[0])))
        else $error("software reset status wrong");
    swr_enable_a: assert property (
        swr_reg && !wr_enable
        |=> enable_reg[15:1] == 15'h0000 && enable_reg[0] == $past(enable_reg[0]))
        else $error("software reset enable wrong");
    rate_nest_a: assert property (
        evt[rid_pkg::BIT_HALF] |-> (&evt[15:8]))
        else $error("2 Hz tick without faster ticks");
    count_expire_a: assert property (
        minute_tick_i && count_reg == 8'h01 && !wr_count && !swr_reg
        |=> count_reg == 8'h00 && status_reg[rid_pkg::BIT_COUNT])
        else $error("countdown expiry missed");
    count_zero_a: assert property (
        wr_count && wr_data_i[7:0] == 8'h00 && !minute_tick_i && !swr_reg
        |=> $stable(count_reg))
        else $error("zero write changed countdown");
    dst_lock_a: assert property (
        daylight_adjust_enable && !wr_ctrl |=> $stable(hour_reg) && $stable(month_reg))
        else $error("daylight bounds changed while enabled");
    irq_gate_a: assert property (
        irq_o |-> $past(|(status_reg & enable_reg)) && !$past(standby_i))
        else $error("interrupt without enabled flag");
    count_read_a: assert property (
        rd_en_i && addr_i == rid_pkg::OFF_COUNT
        |=> rd_data_o == {8'h00, $past(count_reg)})
        else $error("countdown read wrong");

endmodule

// ### test/rid_cpu_model.sv
`timescale 1ns/1ns
module rid_cpu_model (
    input wire logic clk_i,
    output logic [3:0] addr_o,
    output logic [15:0] wr_data_o,
    output logic wr_en_o,
    output logic rd_en_o,
    input wire logic [15:0] rd_data_i
);
    initial
    begin
        addr_o = 4'h0;
        wr_data_o = 16'h0000;
        wr_en_o = 1'b0;
        rd_en_o = 1'b0;
    end

    // ==========================================
    // Bus cycles, lines scrambled once released
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
    begin
        @(posedge clk_i);
        addr_o <= a;
        wr_data_o <= d;
        wr_en_o <= 1'b1;
        @(posedge clk_i);
        wr_en_o <= 1'b0;
        addr_o <= ~a;
        wr_data_o <= ~d;
    end
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] q);
    begin
        @(posedge clk_i);
        addr_o <= a;
        rd_en_o <= 1'b1;
        @(posedge clk_i);
        rd_en_o <= 1'b0;
        addr_o <= ~a;
        #1;
        q = rd_data_i;
    end
    endtask
endmodule

// ### test/rid_irq_countdown_dst_test.sv
`timescale 1ns/1ns
module rid_irq_countdown_dst_test;
    typedef struct packed {logic [4:0] tick; logic [15:0] flag;} rid_row_type;
    localparam int unsigned DIV = 4;
    logic clk = 1'b0;
    logic rst_n;
    logic [3:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [15:0] q;
    logic we;
    logic re;
    logic [4:0] tk;
    logic [3:0] eq;
    logic [3:0] need;
    logic stby;
    logic m59;
    logic [4:0] hr;
    logic [3:0] mo;
    logic irq;
    logic daylight_adjust_enable;
    logic fwd;
    logic back;
    int n_fail;
    int n_compared;
    rid_row_type rows [5] = '{'{5'h10, 16'h0040}, '{5'h08, 16'h0020}, '{5'h04, 16'h0010},
                             '{5'h02, 16'h0008}, '{5'h01, 16'h0001}};

    always #25 clk = ~clk;

    rid_cpu_model cpu (.clk_i(clk), .addr_o(addr), .wr_data_o(wdata), .wr_en_o(we),
        .rd_en_o(re), .rd_data_i(rdata));

    rid_irq_countdown_dst #(.BASE_DIV(DIV)) dut (.core_clk_i(clk), .resetn_i(rst_n),
        .addr_i(addr), .wr_data_i(wdata), .wr_en_i(we), .rd_en_i(re), .rd_data_o(rdata),
        .second_tick_i(tk[4]), .minute_tick_i(tk[3]), .hour_tick_i(tk[2]),
        .day_tick_i(tk[1]), .tamper_event_i(tk[0]), .alarm_hms_eq_i(eq[0]),
        .alarm_day_eq_i(eq[1]), .alarm_month_eq_i(eq[2]), .alarm_year_eq_i(eq[3]),
        .standby_i(stby), .cur_hour_i(hr), .cur_month_i(mo), .minute_59_i(m59),
        .irq_o(irq), .daylight_adjust_enable_o(daylight_adjust_enable), .shift_forward_o(fwd),
        .shift_back_o(back));

    // ==========================================
    // Helpers
    task automatic wrap_up();
    begin
        if (n_fail == 0 && n_compared > 0)
        begin
            $display("Testbench passed");
        end
        else
        begin
            $display("Testbench failed");
        end
        $finish;
    end
    endtask

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
    begin
        n_compared++;
        if (g !== e)
        begin
            $display("[ERR] %0t got %h exp %h", $time, g, e);
            n_fail++;
        end
    end
    endtask

    task automatic rdc(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
    begin
        cpu.rd(a, q);
        chk(q & m, e);
    end
    endtask

    task automatic tick(input logic [4:0] v);
    begin
        @(posedge clk);
        tk <= v;
        @(posedge clk);
        tk <= 5'h00;
    end
    endtask

    task automatic settle();
    begin
        repeat (2) @(posedge clk);
        #1;
    end
    endtask

    task automatic shift(input logic [4:0] h, input logic [3:0] m, input logic [1:0] e);
    begin
        @(posedge clk);
        hr <= h;
        mo <= m;
        m59 <= 1'b1;
        @(posedge clk);
        m59 <= 1'b0;
        #1;
        chk({14'h0000, fwd, back}, {14'h0000, e});
        @(posedge clk);
        #1;
        chk({14'h0000, fwd, back}, 16'h0000);
    end
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        wrap_up();
    end

    // ==========================================
    // Main sequence
    initial
    begin
        rst_n = 1'b0;
        tk = 5'h00;
        eq = 4'h0;
        stby = 1'b0;
        m59 = 1'b0;
        hr = 5'h00;
        mo = 4'h0;
        n_fail = 0;
        n_compared = 0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rdc(rid_pkg::OFF_STATUS, 16'h007f, 16'h0001);
        rdc(rid_pkg::OFF_ENABLE, 16'hffff, 16'h0001);
        rdc(rid_pkg::OFF_COUNT, 16'hffff, 16'h0000);
        chk({15'h0000, irq}, 16'h0001);
        cpu.wr(4'hf, 16'hffff);
        rdc(4'hf, 16'hffff, 16'h0000);
        for (int i = 0; i < 5; i++)
        begin
            cpu.wr(rid_pkg::OFF_STATUS, 16'h007f);
            tick(rows[i].tick);
            rdc(rid_pkg::OFF_STATUS, 16'h007f, rows[i].flag);
        end
        cpu.wr(rid_pkg::OFF_STATUS, 16'h0000);
        rdc(rid_pkg::OFF_STATUS, 16'h0001, 16'h0001);
        cpu.wr(rid_pkg::OFF_STATUS, 16'h0001);
        rdc(rid_pkg::OFF_STATUS, 16'h0001, 16'h0000);
        chk({15'h0000, irq}, 16'h0000);
        cpu.wr(rid_pkg::OFF_COUNT, 16'hab02);
        cpu.wr(rid_pkg::OFF_COUNT, 16'h0000);
        rdc(rid_pkg::OFF_COUNT, 16'hffff, 16'h0002);
        tick(5'h08);
        rdc(rid_pkg::OFF_COUNT, 16'hffff, 16'h0001);
        tick(5'h08);
        rdc(rid_pkg::OFF_COUNT, 16'hffff, 16'h0000);
        rdc(rid_pkg::OFF_STATUS, 16'h0002, 16'h0002);
        chk({15'h0000, irq}, 16'h0000);
        cpu.wr(rid_pkg::OFF_ENABLE, 16'h0002);
        settle();
        chk({15'h0000, irq}, 16'h0001);
        @(posedge clk);
        stby <= 1'b1;
        tick(5'h10);
        settle();
        chk({15'h0000, irq}, 16'h0000);
        rdc(rid_pkg::OFF_STATUS, 16'h0040, 16'h0040);
        @(posedge clk);
        stby <= 1'b0;
        settle();
        chk({15'h0000, irq}, 16'h0001);
        cpu.wr(rid_pkg::OFF_ENABLE, 16'h0000);
        settle();
        chk({15'h0000, irq}, 16'h0000);
        rdc(rid_pkg::OFF_STATUS, 16'h0002, 16'h0002);
        cpu.wr(rid_pkg::OFF_STATUS, 16'h0002);
        tick(5'h08);
        rdc(rid_pkg::OFF_COUNT, 16'hffff, 16'h0000);
        rdc(rid_pkg::OFF_STATUS, 16'h0002, 16'h0000);
        for (int s = 0; s < 4; s++)
        begin
            need = 4'((1 << (s + 1)) - 1);
            cpu.wr(rid_pkg::OFF_CTRL, {12'h000, 2'(s), 2'b00});
            cpu.wr(rid_pkg::OFF_STATUS, 16'h0004);
            @(posedge clk);
            eq <= need >> 1;
            settle();
            rdc(rid_pkg::OFF_STATUS, 16'h0004, 16'h0000);
            @(posedge clk);
            eq <= need;
            settle();
            rdc(rid_pkg::OFF_STATUS, 16'h0004, 16'h0004);
            @(posedge clk);
            eq <= 4'h0;
        end
        cpu.wr(rid_pkg::OFF_ENABLE, 16'h007e);
        cpu.wr(rid_pkg::OFF_COUNT, 16'h0005);
        tick(5'h11);
        cpu.wr(rid_pkg::OFF_HOUR, 16'hffff);
        rdc(rid_pkg::OFF_HOUR, 16'hffff, 16'h1f1f);
        cpu.wr(rid_pkg::OFF_MONTH, 16'hffff);
        rdc(rid_pkg::OFF_MONTH, 16'hffff, 16'h0f0f);
        cpu.wr(rid_pkg::OFF_CTRL, 16'h010c);
        rdc(rid_pkg::OFF_STATUS, 16'h007f, 16'h0001);
        rdc(rid_pkg::OFF_ENABLE, 16'hffff, 16'h0000);
        rdc(rid_pkg::OFF_COUNT, 16'hffff, 16'h0000);
        rdc(rid_pkg::OFF_HOUR, 16'hffff, 16'h1f1f);
        rdc(rid_pkg::OFF_MONTH, 16'hffff, 16'h0f0f);
        cpu.wr(rid_pkg::OFF_HOUR, 16'h0102);
        cpu.wr(rid_pkg::OFF_MONTH, 16'h030a);
        cpu.wr(rid_pkg::OFF_CTRL, 16'h0040);
        settle();
        chk({15'h0000, daylight_adjust_enable}, 16'h0001);
        cpu.wr(rid_pkg::OFF_HOUR, 16'h0000);
        rdc(rid_pkg::OFF_HOUR, 16'hffff, 16'h0102);
        cpu.wr(rid_pkg::OFF_MONTH, 16'h0000);
        rdc(rid_pkg::OFF_MONTH, 16'hffff, 16'h030a);
        shift(5'h01, 4'h3, 2'b10);
        shift(5'h02, 4'ha, 2'b01);
        shift(5'h05, 4'h5, 2'b00);
        cpu.wr(rid_pkg::OFF_CTRL, 16'h0000);
        shift(5'h01, 4'h3, 2'b00);
        cpu.wr(rid_pkg::OFF_STATUS, 16'hfffe);
        repeat (4100) @(posedge clk);
        rdc(rid_pkg::OFF_STATUS, 16'hff80, 16'hff80);
        cpu.wr(rid_pkg::OFF_STATUS, 16'h8000);
        repeat (7) @(posedge clk);
        rdc(rid_pkg::OFF_STATUS, 16'h8000, 16'h8000);
        // Second power-on reset after tamper and enables were cleared
        cpu.wr(rid_pkg::OFF_STATUS, 16'hffff);
        rdc(rid_pkg::OFF_STATUS, 16'h0001, 16'h0000);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rdc(rid_pkg::OFF_STATUS, 16'h00ff, 16'h0001);
        rdc(rid_pkg::OFF_ENABLE, 16'hffff, 16'h0001);
        chk({15'h0000, irq}, 16'h0001);
        wrap_up();
    end
endmodule
